// ### hdl/das_defs.vh
// constants for the drive alarm supervisor: register map, field positions,
// reset values, alarm codes and timing.
// assumes a 125 MHz system clock and a 32-bit AXI4-Lite register port.
`ifndef DAS_DEFS_VH
`define DAS_DEFS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define DAS_REG_CTRL      5'h00
`define DAS_REG_WAIT      5'h04
`define DAS_REG_SUM       5'h08
`define DAS_REG_FIRST     5'h0c
`define DAS_REG_LAST      5'h10
`define DAS_REG_STAT      5'h14
`define DAS_REG_IRQ_STAT  5'h18
`define DAS_REG_IRQ_MASK  5'h1c

// ****************************************************************
// control register fields
// ****************************************************************
`define DAS_CTRL_FIELD_MASK   0
`define DAS_CTRL_SERIAL_MASK  1
`define DAS_CTRL_STALL_MASK   2
`define DAS_CTRL_UNLATCH      3
`define DAS_CTRL_SPEED_MASK   4
`define DAS_CTRL_ENC_MASK     5
`define DAS_CTRL_REMOTE_MASK  6
`define DAS_CTRL_SERIAL_SLAVE 7
`define DAS_CTRL_W            8
`define DAS_CTRL_RST          8'h08

// ****************************************************************
// status register fields
// ****************************************************************
`define DAS_STAT_STALL    0
`define DAS_STAT_REMOTE   1
`define DAS_STAT_DRIVE_OK 2
`define DAS_STAT_LATCHED  3

// ****************************************************************
// interrupt events
// ****************************************************************
`define DAS_EV_NEW_ALARM  0
`define DAS_EV_LATCH      1
`define DAS_EV_REMOTE     2
`define DAS_EV_RESET      3
`define DAS_EV_W          4

// ****************************************************************
// single-bit alarm positions
// ****************************************************************
`define DAS_BIT_SPEED_FBK  6
`define DAS_BIT_ENCODER    7
`define DAS_BIT_FIELD_FAIL 8
`define DAS_BIT_SERIAL_RX  11
`define DAS_BIT_STALL      12

// ****************************************************************
// multi-bit alarm codes, in order of the special alarm inputs
// ****************************************************************
`define DAS_CODE_EXT_TRIP    16'hf005
`define DAS_CODE_REMOTE      16'hf006
`define DAS_CODE_AT_ERROR    16'hf001
`define DAS_CODE_AT_ABORT    16'hf002
`define DAS_CODE_CONFIG      16'hf200
`define DAS_CODE_NO_OPSTAT   16'hf400
`define DAS_CODE_PCB_VER     16'hff05
`define DAS_CODE_PRODUCT     16'hff06
`define DAS_SPC_REMOTE       1
`define DAS_NO_ALARM         16'h0000

// ****************************************************************
// remote trip wait, in tenths of a second
// ****************************************************************
`define DAS_WAIT_MIN         16'h0001
`define DAS_WAIT_MAX         16'h1770
`define DAS_WAIT_RST         16'h0064
`define DAS_TICK_US          100000
`define DAS_CLK_MHZ          125
`define DAS_TICK_CYC         (`DAS_TICK_US * `DAS_CLK_MHZ)

`endif

// ### hdl/das_supervisor.v
// drive alarm supervisor: alarm word, first and latest code, inhibit masks,
// stall flag, delayed remote trip, fault latch and AXI4-Lite registers.
// assumes alarm and start pins are asynchronous and the bus runs on clk_sys.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "das_defs.vh"

module das_supervisor #(
	parameter TICK_CYC = `DAS_TICK_CYC
) (
	input  wire        clk_sys,              // system clock
	input  wire        nrst,                 // asynchronous reset, active low
	input  wire [15:0] alarm_pin,            // single-bit alarm sources
	input  wire [7:0]  special_pin,          // multi-bit code alarm sources
	input  wire        arm_over_stall,       // armature current above stall level
	input  wire        at_zero_speed,        // speed at zero
	input  wire        at_zero_setpoint,     // setpoint at zero
	input  wire        start_input_terminal, // operator start input
	output reg         drive_ok_output,      // high out of reset while no fault latched
	output reg         contactor_open,       // high while a fault opens contactor
	output reg         irq,                  // level interrupt
	input  wire [4:0]  s_axi_awaddr,         // write address
	input  wire        s_axi_awvalid,        // write address valid
	output reg         s_axi_awready,        // write address ready
	input  wire [31:0] s_axi_wdata,          // write data
	input  wire [3:0]  s_axi_wstrb,          // write byte enables
	input  wire        s_axi_wvalid,         // write data valid
	output reg         s_axi_wready,         // write data ready
	output reg  [1:0]  s_axi_bresp,          // write response
	output reg         s_axi_bvalid,         // write response valid
	input  wire        s_axi_bready,         // write response ready
	input  wire [4:0]  s_axi_araddr,         // read address
	input  wire        s_axi_arvalid,        // read address valid
	output reg         s_axi_arready,        // read address ready
	output reg  [31:0] s_axi_rdata,          // read data
	output reg  [1:0]  s_axi_rresp,          // read response
	output reg         s_axi_rvalid,         // read data valid
	input  wire        s_axi_rready          // read data ready
);

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	localparam NSYNC = 28;
	wire [NSYNC-1:0] pin_raw = {start_input_terminal, at_zero_setpoint, at_zero_speed,
		arm_over_stall, special_pin, alarm_pin};
	reg  [NSYNC-1:0] sync1_q, sync2_q, sync3_q, pin_q;
	wire [NSYNC-1:0] pin_d = (sync2_q & ~(sync2_q ^ sync3_q)) | (pin_q & (sync2_q ^ sync3_q));

	// a change counts only once the second and third stages agree
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sync1_q <= {NSYNC{1'b0}};
			sync2_q <= {NSYNC{1'b0}};
			sync3_q <= {NSYNC{1'b0}};
			pin_q   <= {NSYNC{1'b0}};
		end else begin
			sync1_q <= pin_raw;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			pin_q   <= pin_d;
		end
	end

	wire [15:0] alm_in   = pin_q[15:0];
	wire [7:0]  spc_in   = pin_q[23:16];
	wire        over_stl = pin_q[24];
	wire        zero_spd = pin_q[25];
	wire        zero_set = pin_q[26];
	wire        start_in = pin_q[27];

	// ****************************************************************
	// software settings
	// ****************************************************************
	reg  [`DAS_CTRL_W-1:0] ctrl_q;
	reg  [15:0]            wait_q;
	reg  [`DAS_EV_W-1:0]   irq_stat_q, irq_mask_q;
	wire slave_mode = ctrl_q[`DAS_CTRL_SERIAL_SLAVE];

	// ****************************************************************
	// alarm word
	// ****************************************************************
	reg  [15:0] sum_q;
	reg  [15:0] sum_d;
	wire        stall_fail = over_stl & zero_spd & ~zero_set;

	always @* begin
		sum_d = alm_in;
		sum_d[`DAS_BIT_FIELD_FAIL] = alm_in[`DAS_BIT_FIELD_FAIL]
			& ~ctrl_q[`DAS_CTRL_FIELD_MASK];
		sum_d[`DAS_BIT_SERIAL_RX] = alm_in[`DAS_BIT_SERIAL_RX] & slave_mode
			& ~ctrl_q[`DAS_CTRL_SERIAL_MASK];
		sum_d[`DAS_BIT_SPEED_FBK] = alm_in[`DAS_BIT_SPEED_FBK]
			& ~ctrl_q[`DAS_CTRL_SPEED_MASK];
		sum_d[`DAS_BIT_ENCODER] = alm_in[`DAS_BIT_ENCODER]
			& ~ctrl_q[`DAS_CTRL_ENC_MASK];
		sum_d[`DAS_BIT_STALL] = stall_fail;
	end

	// ****************************************************************
	// remote trip wait
	// ****************************************************************
	// the wait counts in tenths of a second; a wait of zero acts as the minimum
	wire        rt_req = spc_in[`DAS_SPC_REMOTE] & ~ctrl_q[`DAS_CTRL_REMOTE_MASK];
	reg  [23:0] tick_q;
	reg  [15:0] tenth_q;
	reg         rt_q;
	wire        tick_end = (tick_q == TICK_CYC - 1);
	wire [15:0] wait_eff = (wait_q < `DAS_WAIT_MIN) ? `DAS_WAIT_MIN : wait_q;

	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			tick_q  <= 24'h000000;
			tenth_q <= 16'h0000;
			rt_q    <= 1'b0;
		end else if (!rt_req) begin
			tick_q  <= 24'h000000;
			tenth_q <= 16'h0000;
			rt_q    <= 1'b0;
		end else if (!rt_q) begin
			tick_q <= tick_end ? 24'h000000 : tick_q + 24'h000001;
			if (tick_end) begin
				tenth_q <= tenth_q + 16'h0001;
				if (tenth_q + 16'h0001 >= wait_eff)
					rt_q <= 1'b1;
			end
		end
	end

	// special alarms as seen by the supervisor: remote trip only once its wait is over
	wire [7:0] spc_act = (spc_in & ~(8'h01 << `DAS_SPC_REMOTE))
		| ({7'h00, rt_q} << `DAS_SPC_REMOTE);

	// ****************************************************************
	// latest and first alarm codes
	// ****************************************************************
	function [15:0] spc_code;
		input [2:0] idx;
		begin
			case (idx)
				3'h0: spc_code = `DAS_CODE_EXT_TRIP;
				3'h1: spc_code = `DAS_CODE_REMOTE;
				3'h2: spc_code = `DAS_CODE_AT_ERROR;
				3'h3: spc_code = `DAS_CODE_AT_ABORT;
				3'h4: spc_code = `DAS_CODE_CONFIG;
				3'h5: spc_code = `DAS_CODE_NO_OPSTAT;
				3'h6: spc_code = `DAS_CODE_PCB_VER;
				default: spc_code = `DAS_CODE_PRODUCT;
			endcase
		end
	endfunction

	reg  [15:0] sum_hold_q, last_q, first_q;
	reg  [7:0]  spc_q;
	wire [15:0] new_bits = sum_d & ~sum_hold_q;
	wire [7:0]  new_spc  = spc_act & ~spc_q;
	wire        any_now  = (sum_d != 16'h0000) | (spc_act != 8'h00);
	wire        any_was  = (sum_hold_q != 16'h0000) | (spc_q != 8'h00);
	reg  [15:0] new_code;
	integer     i;

	// when several alarms rise together the highest code position is reported
	always @* begin
		new_code = `DAS_NO_ALARM;
		for (i = 0; i < 16; i = i + 1)
			if (new_bits[i])
				new_code = 16'h0001 << i;
		for (i = 0; i < 8; i = i + 1)
			if (new_spc[i])
				new_code = spc_code(i[2:0]);
	end

	wire new_alarm = (new_bits != 16'h0000) | (new_spc != 8'h00);

	// ****************************************************************
	// fault latch
	// ****************************************************************
	reg  latched_q, start_q;
	wire [15:0] trip_bits = sum_d & ~({15'h0000, ctrl_q[`DAS_CTRL_STALL_MASK]}
		<< `DAS_BIT_STALL);
	wire trip_now  = (trip_bits != 16'h0000) | (spc_act != 8'h00);
	wire start_low = start_q & ~start_in;
	wire unlatch   = ctrl_q[`DAS_CTRL_UNLATCH] & start_low;

	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sum_hold_q <= 16'h0000;
			spc_q      <= 8'h00;
			last_q     <= `DAS_NO_ALARM;
			first_q    <= `DAS_NO_ALARM;
			latched_q  <= 1'b0;
			start_q    <= 1'b0;
		end else begin
			sum_hold_q <= sum_d;
			spc_q      <= spc_act;
			start_q    <= start_in;
			if (!any_now)
				last_q <= `DAS_NO_ALARM;
			else if (new_alarm)
				last_q <= new_code;
			// a new alarm in the reset cycle is lost while a first code is held: capture wins over clear only when none is held
			if (new_alarm && !any_was && first_q == `DAS_NO_ALARM)
				first_q <= new_code;
			else if (unlatch)
				first_q <= `DAS_NO_ALARM;
			// a fault present in the reset cycle keeps the latch set
			if (trip_now)
				latched_q <= 1'b1;
			else if (unlatch)
				latched_q <= 1'b0;
		end
	end

	// ****************************************************************
	// interrupt status
	// ****************************************************************
	wire [`DAS_EV_W-1:0] ev;
	assign ev[`DAS_EV_NEW_ALARM] = new_alarm;
	assign ev[`DAS_EV_LATCH]     = trip_now & ~latched_q;
	assign ev[`DAS_EV_REMOTE]    = rt_q & ~spc_q[`DAS_SPC_REMOTE];
	assign ev[`DAS_EV_RESET]     = unlatch & ~trip_now & latched_q;

	// ****************************************************************
	// AXI4-Lite slave
	// ****************************************************************
	reg  [4:0]  awaddr_q;
	reg  [31:0] wdata_q;
	reg  [3:0]  wstrb_q;
	reg         aw_have_q, w_have_q;
	wire        aw_take = s_axi_awvalid & s_axi_awready;
	wire        w_take  = s_axi_wvalid & s_axi_wready;
	wire        do_wr   = aw_have_q & w_have_q & ~s_axi_bvalid;
	wire        wr_ok   = (awaddr_q[1:0] == 2'b00) && (awaddr_q <= `DAS_REG_IRQ_MASK);
	wire [`DAS_EV_W-1:0] w1c = (do_wr && awaddr_q == `DAS_REG_IRQ_STAT && wstrb_q[0])
		? wdata_q[`DAS_EV_W-1:0] : {`DAS_EV_W{1'b0}};
	reg  [31:0] rd_d;
	reg         rd_ok;

	always @* begin
		rd_d  = 32'h00000000;
		rd_ok = 1'b1;
		case (s_axi_araddr)
			`DAS_REG_CTRL:     rd_d = {24'h000000, ctrl_q};
			`DAS_REG_WAIT:     rd_d = {16'h0000, wait_q};
			`DAS_REG_SUM:      rd_d = {16'h0000, sum_hold_q};
			`DAS_REG_FIRST:    rd_d = {16'h0000, first_q};
			`DAS_REG_LAST:     rd_d = {16'h0000, last_q};
			`DAS_REG_STAT:     rd_d = {28'h0000000, latched_q, ~latched_q, rt_q,
				sum_hold_q[`DAS_BIT_STALL]};
			`DAS_REG_IRQ_STAT: rd_d = {28'h0000000, irq_stat_q};
			`DAS_REG_IRQ_MASK: rd_d = {28'h0000000, irq_mask_q};
			default:           rd_ok = 1'b0;
		endcase
	end

	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= 2'b00;
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			awaddr_q      <= 5'h00;
			wdata_q       <= 32'h00000000;
			wstrb_q       <= 4'h0;
			ctrl_q        <= `DAS_CTRL_RST;
			wait_q        <= `DAS_WAIT_RST;
			irq_mask_q    <= {`DAS_EV_W{1'b0}};
			irq_stat_q    <= {`DAS_EV_W{1'b0}};
			irq           <= 1'b0;
			drive_ok_output <= 1'b0;
			contactor_open  <= 1'b0;
		end else begin
			// address and data are taken separately, in either order
			s_axi_awready <= ~aw_have_q & ~aw_take & ~s_axi_bvalid;
			s_axi_wready  <= ~w_have_q & ~w_take & ~s_axi_bvalid;
			if (aw_take) begin
				aw_have_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (w_take) begin
				w_have_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
				case (awaddr_q)
					`DAS_REG_CTRL:
						if (wstrb_q[0])
							ctrl_q <= wdata_q[`DAS_CTRL_W-1:0];
					`DAS_REG_WAIT: begin
						if (wstrb_q[0])
							wait_q[7:0] <= wdata_q[7:0];
						if (wstrb_q[1])
							wait_q[15:8] <= wdata_q[15:8];
					end
					`DAS_REG_IRQ_MASK:
						if (wstrb_q[0])
							irq_mask_q <= wdata_q[`DAS_EV_W-1:0];
					default: ;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			// one read at a time: address taken, data one cycle later
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			if (s_axi_arready && s_axi_arvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_d;
				s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			// event set wins over a write-one clear in the same cycle
			irq_stat_q <= (irq_stat_q & ~w1c) | ev;
			irq        <= |(((irq_stat_q & ~w1c) | ev) & irq_mask_q);
			drive_ok_output <= ~(latched_q | trip_now) | (unlatch & ~trip_now);
			contactor_open  <= (latched_q | trip_now) & ~(unlatch & ~trip_now);
		end
	end

endmodule

// ### test/das_supervisor_checker.sv
// port checker for the drive alarm supervisor, bound beside the design.
// assumes pins are held steady well past the three-flop synchroniser.
`timescale 1ns/1ps
module das_supervisor_checker (
	input wire        clk_sys,              // system clock
	input wire        nrst,                 // asynchronous reset, active low
	input wire [15:0] alarm_pin,            // single-bit alarm sources
	input wire [7:0]  special_pin,          // multi-bit code alarm sources
	input wire        start_input_terminal, // operator start input
	input wire        drive_ok_output,      // no fault latched and not in reset
	input wire        contactor_open,       // fault opens contactor
	input wire        s_axi_arvalid,        // read address valid
	input wire        s_axi_arready,        // read address ready
	input wire        s_axi_rvalid,         // read data valid
	input wire        s_axi_rready,         // read data ready
	input wire [31:0] s_axi_rdata,          // read data
	input wire        s_axi_bvalid,         // write response valid
	input wire        s_axi_bready,         // write response ready
	input wire [1:0]  s_axi_bresp           // write response
);
	// ****************************************************************
	// helper counters
	// ****************************************************************
	reg [3:0] fall_q;
	reg [3:0] rst_q;
	reg       start_q;
	// saturating ages, so a rise of drive ok can be tied to its cause
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			fall_q  <= 4'hf;
			rst_q   <= 4'h0;
			start_q <= 1'b1;
		end else begin
			start_q <= start_input_terminal;
			if (start_q && !start_input_terminal)
				fall_q <= 4'h0;
			else if (fall_q != 4'hf)
				fall_q <= fall_q + 4'h1;
			if (rst_q != 4'hf)
				rst_q <= rst_q + 4'h1;
		end
	end
	// ****************************************************************
	// properties
	// ****************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	a_ok_inverse: assert property (nrst && $past(nrst) |-> drive_ok_output == !contactor_open)
		else $error("contactor state disagrees with drive ok");
	a_ok_cause: assert property ($rose(drive_ok_output) |-> rst_q < 4'h3 || (fall_q >= 4'h1 && fall_q <= 4'h8))
		else $error("drive ok rose without a start falling edge");
	a_overspeed_trip: assert property (alarm_pin[0] [*8] |=> !drive_ok_output)
		else $error("overspeed alarm did not drop drive ok");
	a_ext_trip: assert property (special_pin[0] [*8] |=> contactor_open)
		else $error("external trip did not open contactor");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
		else $error("read address ready held");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not held");
	c_fault: cover property ($fell(drive_ok_output));
	c_restore: cover property ($rose(drive_ok_output) && fall_q <= 4'h8);
	c_read_stall: cover property (s_axi_rvalid && !s_axi_rready);
endmodule

// ### test/das_operator.sv
// operator start switch and contactor coil beside the drive alarm supervisor.
// assumes toggle_req is a one-cycle pulse from the bench on clk_sys.
`timescale 1ns/1ps
module das_operator #(
	parameter HOLD = 6
) (
	input  wire clk_sys,              // system clock
	input  wire toggle_req,           // cycle the start switch off then on
	input  wire drive_ok_output,      // drive ok from the supervisor
	output reg  start_input_terminal, // start level to the supervisor
	output reg  coil_on               // coil held in by start and drive ok
);
	reg [3:0] off_q;
	initial begin
		start_input_terminal = 1'b1;
		coil_on = 1'b0;
		off_q = 4'h0;
	end
	// switch held off long enough for the synchroniser to see it
	always @(posedge clk_sys) begin
		if (toggle_req) begin
			start_input_terminal <= 1'b0;
			off_q <= HOLD[3:0];
		end else if (off_q != 4'h0) begin
			off_q <= off_q - 4'h1;
			if (off_q == 4'h1)
				start_input_terminal <= 1'b1;
		end
		coil_on <= start_input_terminal && drive_ok_output;
	end
endmodule

// ### test/das_supervisor_test.sv
// self-checking bench for the drive alarm supervisor with an operator model.
// assumes 125 MHz and a tick shortened to 10 cycles for the trip wait.
`timescale 1ns/1ps
`include "das_defs.vh"
module das_supervisor_test;
	localparam TICK = 10;
	// ****************************************************************
	// signals
	// ****************************************************************
	reg         clk_sys, nrst, toggle_req, arm_over_stall, at_zero_speed, at_zero_setpoint;
	reg  [15:0] alarm_pin;
	reg  [7:0]  special_pin;
	reg  [4:0]  awaddr, araddr;
	reg  [31:0] wdata, rd, rnd;
	reg  [3:0]  wstrb;
	reg         awvalid, wvalid, bready, arvalid, rready;
	reg  [1:0]  resp;
	reg  [12:0] t;
	wire        drive_ok_output, contactor_open, irq, start_input_terminal;
	wire        awready, wready, bvalid, arready, rvalid;
	wire [1:0]  bresp, rresp;
	wire [31:0] rdata;
	integer     seed, bad_count, checked, cycles, i, k, ba, bb, w, dly;
	das_supervisor #(.TICK_CYC(TICK)) u_das_supervisor (
		.clk_sys(clk_sys), .nrst(nrst), .alarm_pin(alarm_pin), .special_pin(special_pin),
		.arm_over_stall(arm_over_stall), .at_zero_speed(at_zero_speed),
		.at_zero_setpoint(at_zero_setpoint), .start_input_terminal(start_input_terminal),
		.drive_ok_output(drive_ok_output), .contactor_open(contactor_open), .irq(irq),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	das_operator u_das_operator (.clk_sys(clk_sys), .toggle_req(toggle_req),
		.drive_ok_output(drive_ok_output), .start_input_terminal(start_input_terminal),
		.coil_on());
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	// ****************************************************************
	// tasks
	// ****************************************************************
	task finish_test;
		begin
			$display("comparisons %0d mismatches %0d", checked, bad_count);
			if (bad_count == 0 && checked > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task wait_cyc(input integer n);
		repeat (n) @(posedge clk_sys);
	endtask
	// response ready is held back 0..3 cycles to stall the slave
	task axi_wr(input [4:0] a, input [31:0] d);
		begin
			awaddr <= a;
			wdata <= d;
			wstrb <= 4'hf;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			dly = $unsigned($random(seed)) % 4;
			@(posedge clk_sys);
			while (awvalid || wvalid || !(bvalid && bready)) begin
				if (awready)
					awvalid <= 1'b0;
				if (wready)
					wvalid <= 1'b0;
				if (dly == 0)
					bready <= 1'b1;
				else
					dly = dly - 1;
				@(posedge clk_sys);
			end
			resp = bresp;
			bready <= 1'b0;
			@(posedge clk_sys);
		end
	endtask
	task axi_rd(input [4:0] a);
		begin
			araddr <= a;
			arvalid <= 1'b1;
			dly = $unsigned($random(seed)) % 4;
			@(posedge clk_sys);
			while (arvalid || !(rvalid && rready)) begin
				if (arready)
					arvalid <= 1'b0;
				if (dly == 0)
					rready <= 1'b1;
				else
					dly = dly - 1;
				@(posedge clk_sys);
			end
			rd = rdata;
			resp = rresp;
			rready <= 1'b0;
			@(posedge clk_sys);
		end
	endtask
	task rdchk(input [4:0] a, input [31:0] m, input [31:0] e);
		begin
			axi_rd(a);
			chk(rd & m, e);
		end
	endtask
	// clear every alarm source, then cycle the start switch
	task recover;
		begin
			alarm_pin <= 16'h0;
			special_pin <= 8'h0;
			{arm_over_stall, at_zero_speed, at_zero_setpoint} <= 3'h0;
			wait_cyc(8);
			toggle_req <= 1'b1;
			@(posedge clk_sys);
			toggle_req <= 1'b0;
			wait_cyc(16);
		end
	endtask
	task pick(output integer n, input integer avoid);
		begin
			n = avoid;
			while (n == avoid || n == 6 || n == 7 || n == 8 || n == 11 || n == 12)
				n = $unsigned($random(seed)) % 16;
		end
	endtask
	function [15:0] spc_code(input [2:0] n);
		case (n)
			3'h0: spc_code = `DAS_CODE_EXT_TRIP;
			3'h1: spc_code = `DAS_CODE_REMOTE;
			3'h2: spc_code = `DAS_CODE_AT_ERROR;
			3'h3: spc_code = `DAS_CODE_AT_ABORT;
			3'h4: spc_code = `DAS_CODE_CONFIG;
			3'h5: spc_code = `DAS_CODE_NO_OPSTAT;
			3'h6: spc_code = `DAS_CODE_PCB_VER;
			default: spc_code = `DAS_CODE_PRODUCT;
		endcase
	endfunction
	// alarm bit, control value, alarm visible
	function [12:0] mask_case(input [2:0] n);
		case (n)
			3'h0: mask_case = {4'h8, 8'h09, 1'b0};
			3'h1: mask_case = {4'h8, 8'h08, 1'b1};
			3'h2: mask_case = {4'h6, 8'h18, 1'b0};
			3'h3: mask_case = {4'h7, 8'h28, 1'b0};
			3'h4: mask_case = {4'hb, 8'h8a, 1'b0};
			3'h5: mask_case = {4'hb, 8'h08, 1'b0};
			default: mask_case = {4'hb, 8'h88, 1'b1};
		endcase
	endfunction
	always @(posedge clk_sys) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			bad_count = bad_count + 1;
			finish_test;
		end
	end
	// ****************************************************************
	// scenarios
	// ****************************************************************
	initial begin
		{nrst, toggle_req, arm_over_stall, at_zero_speed, at_zero_setpoint} = 5'h0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{alarm_pin, special_pin, awaddr, araddr, wdata, wstrb} = 0;
		seed = 73095;
		bad_count = 0;
		checked = 0;
		cycles = 0;
		repeat (6) @(posedge clk_sys);
		nrst <= 1'b1;
		@(posedge clk_sys);
		rdchk(`DAS_REG_CTRL, ~32'h0, 32'h8);
		rdchk(`DAS_REG_WAIT, ~32'h0, 32'h64);
		rdchk(`DAS_REG_SUM, ~32'h0, 32'h0);
		rdchk(`DAS_REG_FIRST, ~32'h0, 32'h0);
		rdchk(`DAS_REG_LAST, ~32'h0, 32'h0);
		rdchk(`DAS_REG_STAT, ~32'h0, 32'h4);
		rdchk(5'h02, ~32'h0, 32'h0);
		chk({30'h0, resp}, 32'h2);
		axi_wr(`DAS_REG_IRQ_MASK, 32'h1);
		chk({30'h0, resp}, 32'h0);
		for (i = 0; i < 4; i = i + 1) begin
			pick(ba, -1);
			pick(bb, ba);
			alarm_pin <= 16'h1 << ba;
			wait_cyc(8);
			alarm_pin <= (16'h1 << ba) | (16'h1 << bb);
			wait_cyc(8);
			rdchk(`DAS_REG_SUM, ~32'h0, (32'h1 << ba) | (32'h1 << bb));
			rdchk(`DAS_REG_FIRST, ~32'h0, 32'h1 << ba);
			rdchk(`DAS_REG_LAST, ~32'h0, 32'h1 << bb);
			chk({31'h0, irq}, (i == 0) ? 32'h1 : 32'h0);
			rdchk(`DAS_REG_IRQ_STAT, 32'h1, 32'h1);
			axi_wr(`DAS_REG_IRQ_STAT, 32'hf);
			chk({31'h0, irq}, 32'h0);
			if (i == 0)
				axi_wr(`DAS_REG_IRQ_MASK, 32'h0);
			alarm_pin <= 16'h0;
			wait_cyc(8);
			rdchk(`DAS_REG_LAST, ~32'h0, 32'h0);
			chk({31'h0, drive_ok_output}, 32'h0);
			recover;
			rdchk(`DAS_REG_FIRST, ~32'h0, 32'h0);
			chk({31'h0, drive_ok_output}, 32'h1);
		end
		for (k = 0; k < 7; k = k + 1) begin
			t = mask_case(k[2:0]);
			axi_wr(`DAS_REG_CTRL, {24'h0, t[8:1]});
			alarm_pin <= 16'h1 << t[12:9];
			wait_cyc(8);
			rdchk(`DAS_REG_SUM, ~32'h0, t[0] ? (32'h1 << t[12:9]) : 32'h0);
			chk({31'h0, drive_ok_output}, {31'h0, !t[0]});
			recover;
		end
		axi_wr(`DAS_REG_CTRL, 32'hc);
		for (k = 0; k < 8; k = k + 1) begin
			{arm_over_stall, at_zero_speed, at_zero_setpoint} <= k[2:0];
			wait_cyc(8);
			rdchk(`DAS_REG_STAT, 32'h1, {31'h0, k[2] & k[1] & ~k[0]});
			chk({31'h0, drive_ok_output}, 32'h1);
		end
		axi_wr(`DAS_REG_CTRL, 32'h8);
		{arm_over_stall, at_zero_speed, at_zero_setpoint} <= 3'h6;
		wait_cyc(8);
		chk({31'h0, contactor_open}, 32'h1);
		recover;
		rnd = $random(seed);
		w = 1 + rnd[1:0];
		axi_wr(`DAS_REG_WAIT, w);
		special_pin <= 8'h02;
		wait_cyc(w * TICK - 6);
		rdchk(`DAS_REG_STAT, 32'h6, 32'h4);
		wait_cyc(20);
		rdchk(`DAS_REG_STAT, 32'h6, 32'h2);
		rdchk(`DAS_REG_LAST, ~32'h0, {16'h0, spc_code(3'h1)});
		special_pin <= 8'h0;
		wait_cyc(8);
		rdchk(`DAS_REG_STAT, 32'h2, 32'h0);
		recover;
		axi_wr(`DAS_REG_CTRL, 32'h48);
		special_pin <= 8'h02;
		wait_cyc(w * TICK + 20);
		rdchk(`DAS_REG_STAT, 32'h6, 32'h4);
		recover;
		axi_wr(`DAS_REG_CTRL, 32'h0);
		alarm_pin <= 16'h1;
		wait_cyc(8);
		recover;
		chk({31'h0, drive_ok_output}, 32'h0);
		axi_wr(`DAS_REG_CTRL, 32'h8);
		recover;
		chk({31'h0, drive_ok_output}, 32'h1);
		for (k = 0; k < 8; k = k + 1) begin
			if (k != 1) begin
				special_pin <= 8'h1 << k;
				wait_cyc(8);
				rdchk(`DAS_REG_LAST, ~32'h0, {16'h0, spc_code(k[2:0])});
				rdchk(`DAS_REG_FIRST, ~32'h0, {16'h0, spc_code(k[2:0])});
				recover;
			end
		end
		finish_test;
	end
endmodule
bind das_supervisor das_supervisor_checker u_das_supervisor_checker (
	.clk_sys(clk_sys), .nrst(nrst), .alarm_pin(alarm_pin), .special_pin(special_pin),
	.start_input_terminal(start_input_terminal), .drive_ok_output(drive_ok_output),
	.contactor_open(contactor_open), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_bresp(s_axi_bresp));
